// ==== include/mmd_pkg.sv ====
package mmd_pkg;

  // ---------------------------------------------------------------
  // Instruction group selected by the fetch path
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    MMD_STACK_SLOT_MOVE,
    MMD_LOAD_EFFECTIVE_ADDRESS_MOVE,
    MMD_NIBBLE_DIRECTION_MOVE,
    MMD_SIGN_EXTENDED_IMMEDIATE_MOVE,
    MMD_SIGNED_MULTIPLY_IMM,
    MMD_SIGNED_MULTIPLY_SRC_DST,
    MMD_SIGNED_MULTIPLY_LONG,
    MMD_EXTENDED_MULTIPLY,
    MMD_OTHER
  } mmd_kind_e;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int MMD_FIELD_W = 5;
  localparam int MMD_LEN_W = 4;
  localparam int MMD_CYC_W = 5;

  // ---------------------------------------------------------------
  // Prefix bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] MMD_PFX_DST_IND = 8'h09;
  localparam logic [7:0] MMD_PFX_SRC_IND = 8'h41;
  localparam logic [7:0] MMD_PFX_BOTH_IND = 8'h49;

  // ---------------------------------------------------------------
  // Five-bit operand codes
  // ---------------------------------------------------------------
  localparam logic [4:0] MMD_OP_DR0 = 5'h12;
  localparam logic [4:0] MMD_OP_DR1 = 5'h13;
  localparam logic [4:0] MMD_OP_DR2 = 5'h10;
  localparam logic [4:0] MMD_OP_DR3 = 5'h11;
  localparam logic [4:0] MMD_OP_AN0 = 5'h02;
  localparam logic [4:0] MMD_OP_AN1 = 5'h03;
  localparam logic [4:0] MMD_OP_IND0 = 5'h00;
  localparam logic [4:0] MMD_OP_IND1 = 5'h01;
  localparam logic [4:0] MMD_OP_D8AN0 = 5'h04;
  localparam logic [4:0] MMD_OP_D8AN1 = 5'h05;
  localparam logic [4:0] MMD_OP_D8SB = 5'h06;
  localparam logic [4:0] MMD_OP_D8FB = 5'h07;
  localparam logic [4:0] MMD_OP_D16AN0 = 5'h08;
  localparam logic [4:0] MMD_OP_D16AN1 = 5'h09;
  localparam logic [4:0] MMD_OP_D16SB = 5'h0a;
  localparam logic [4:0] MMD_OP_D16FB = 5'h0b;
  localparam logic [4:0] MMD_OP_D24AN0 = 5'h0c;
  localparam logic [4:0] MMD_OP_D24AN1 = 5'h0d;
  localparam logic [4:0] MMD_OP_ABS24 = 5'h0e;
  localparam logic [4:0] MMD_OP_ABS16 = 5'h0f;

  // Extension bytes per operand class
  localparam logic [1:0] MMD_EXT_NONE = 2'h0;
  localparam logic [1:0] MMD_EXT_8 = 2'h1;
  localparam logic [1:0] MMD_EXT_16 = 2'h2;
  localparam logic [1:0] MMD_EXT_24 = 2'h3;

  // ---------------------------------------------------------------
  // Nibble direction field
  // ---------------------------------------------------------------
  localparam logic [1:0] MMD_NIB_FORM_R0L_SRC = 2'h1;
  localparam logic [1:0] MMD_NIB_FORM_R0L_DST = 2'h0;

  // ---------------------------------------------------------------
  // Address-load destination field
  // ---------------------------------------------------------------
  localparam logic [2:0] MMD_LEA_MAX_DEST = 3'h3;

  // ---------------------------------------------------------------
  // Base lengths in bytes
  // ---------------------------------------------------------------
  localparam logic [3:0] MMD_LEN_OPC2 = 4'h2;
  localparam logic [3:0] MMD_LEN_OPC3 = 4'h3;
  localparam logic [3:0] MMD_LEN_ONE = 4'h1;

  // ---------------------------------------------------------------
  // Cycle figures
  // ---------------------------------------------------------------
  localparam logic [4:0] MMD_CYC_STACK = 5'h03;
  localparam logic [4:0] MMD_CYC_LEA = 5'h02;
  localparam logic [4:0] MMD_CYC_NIB_KEEP_REG = 5'h03;
  localparam logic [4:0] MMD_CYC_NIB_KEEP_MEM = 5'h05;
  localparam logic [4:0] MMD_CYC_NIB_SWAP_REG = 5'h06;
  localparam logic [4:0] MMD_CYC_NIB_SWAP_MEM = 5'h08;
  localparam logic [4:0] MMD_CYC_SIGN_EXTENDED_IMMEDIATE_MOVE = 5'h02;
  localparam logic [4:0] MMD_CYC_MUL_REG = 5'h03;
  localparam logic [4:0] MMD_CYC_MUL_ONE_MEM = 5'h05;
  localparam logic [4:0] MMD_CYC_MUL_TWO_MEM = 5'h06;
  localparam logic [4:0] MMD_CYC_MULL_REG = 5'h08;
  localparam logic [4:0] MMD_CYC_MULL_MEM = 5'h09;
  localparam logic [4:0] MMD_CYC_EXTENDED_MULTIPLY_REG = 5'h08;
  localparam logic [4:0] MMD_CYC_EXTENDED_MULTIPLY_MEM = 5'h0a;
  localparam logic [4:0] MMD_CYC_IND_ONE = 5'h03;
  localparam logic [4:0] MMD_CYC_IND_TWO = 5'h06;

endpackage

// ==== include/mmd_opnd_if.sv ====
interface mmd_opnd_if;
  logic [4:0] field;
  logic is_data;
  logic is_addr;
  logic is_mem;
  logic known;
  logic [1:0] ext;

  modport cls (input field, output is_data, is_addr, is_mem, known, ext);
  modport dec (output field, input is_data, is_addr, is_mem, known, ext);
endinterface

// ==== hdl/mmd_operand_class.sv ====
module mmd_operand_class (
  mmd_opnd_if.cls op
);
  import mmd_pkg::*;

  // ---------------------------------------------------------------
  // Five-bit operand code classification
  // ---------------------------------------------------------------
  always_comb begin
    op.is_data = 1'b0;
    op.is_addr = 1'b0;
    op.is_mem = 1'b1;
    op.known = 1'b1;
    op.ext = MMD_EXT_NONE;
    case (op.field)
      MMD_OP_DR0, MMD_OP_DR1, MMD_OP_DR2, MMD_OP_DR3: begin
        op.is_data = 1'b1;
        op.is_mem = 1'b0;
      end
      MMD_OP_AN0, MMD_OP_AN1: begin
        op.is_addr = 1'b1;
        op.is_mem = 1'b0;
      end
      MMD_OP_IND0, MMD_OP_IND1: begin
        op.ext = MMD_EXT_NONE;
      end
      MMD_OP_D8AN0, MMD_OP_D8AN1, MMD_OP_D8SB, MMD_OP_D8FB: begin
        op.ext = MMD_EXT_8;
      end
      MMD_OP_D16AN0, MMD_OP_D16AN1, MMD_OP_D16SB, MMD_OP_D16FB, MMD_OP_ABS16: begin
        op.ext = MMD_EXT_16;
      end
      MMD_OP_D24AN0, MMD_OP_D24AN1, MMD_OP_ABS24: begin
        op.ext = MMD_EXT_24;
      end
      default: begin
        op.known = 1'b0;
        op.is_mem = 1'b0;
      end
    endcase
  end

endmodule

// ==== hdl/mmd_decoder.sv ====
// Function
// - Prefix 09 marks single destination indirect
// - Two-operand multiply prefixes 41, 09, 49
// - Extended multiply prefix 09 marks source indirect
// - One indirect operand: plus 1 byte, 3 cycles
// - Both indirect: plus 1 byte, 6 cycles
// - Word immediate multiply adds one byte
// - Word multiply destination register only
// - Long multiply refuses any prefix
// - Nibble direction codes 01xx and 00xx
// - Nibble keep 3/5, swap 6/8 cycles
// - Address-load displacement/absolute sources, 2 cycles
// - Stack slot move always 3 cycles
// - Five-bit operand codes per table
// - Sign-extended move 2 cycles, pairs/address registers
// - Long multiply 8 register, 9 memory
// - Extended multiply 8/10, of data registers only the fourth
// - Size bit 0 byte, 1 word
module mmd_decoder (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic dec_valid_i,
  input wire mmd_pkg::mmd_kind_e kind_i,
  input wire logic size_i,
  input wire logic prefix_valid_i,
  input wire logic [7:0] prefix_i,
  input wire logic [mmd_pkg::MMD_FIELD_W-1:0] src_field_i,
  input wire logic [mmd_pkg::MMD_FIELD_W-1:0] dst_field_i,
  input wire logic [3:0] dir_i,
  input wire logic [2:0] dest_sel_i,
  output logic done_o,
  output logic [mmd_pkg::MMD_LEN_W-1:0] length_o,
  output logic [mmd_pkg::MMD_CYC_W-1:0] cycles_o,
  output logic src_ind_o,
  output logic dst_ind_o,
  output logic size_word_o,
  output logic nibble_swap_o,
  output logic illegal_o
);
  import mmd_pkg::*;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_s1_d;
  logic rst_s2_d;

  always_comb begin
    rst_s1_d = 1'b1;
    rst_s2_d = rst_s1_q;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= rst_s1_d;
      rst_s2_q <= rst_s2_d;
    end
  end

  // ---------------------------------------------------------------
  // Operand classification
  // ---------------------------------------------------------------
  mmd_opnd_if src_if ();
  mmd_opnd_if dst_if ();

  assign src_if.field = src_field_i;
  assign dst_if.field = dst_field_i;

  mmd_operand_class u_src_class (
    .op (src_if.cls)
  );

  mmd_operand_class u_dst_class (
    .op (dst_if.cls)
  );

  // ---------------------------------------------------------------
  // Prefix interpretation
  // ---------------------------------------------------------------
  logic pfx_dst;
  logic pfx_src;
  logic pfx_both;
  logic pfx_bad;

  always_comb begin
    pfx_dst = prefix_valid_i && (prefix_i == MMD_PFX_DST_IND);
    pfx_src = prefix_valid_i && (prefix_i == MMD_PFX_SRC_IND);
    pfx_both = prefix_valid_i && (prefix_i == MMD_PFX_BOTH_IND);
    pfx_bad = prefix_valid_i && !pfx_dst && !pfx_src && !pfx_both;
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic [3:0] len_d;
  logic [4:0] cyc_d;
  logic src_ind_d;
  logic dst_ind_d;
  logic ill_d;
  logic swap_d;
  logic [3:0] src_ext;
  logic [3:0] dst_ext;
  logic nib_mem;
  logic one_ind;
  logic both_ind;

  always_comb begin
    src_ext = {2'h0, src_if.ext};
    dst_ext = {2'h0, dst_if.ext};
    len_d = MMD_LEN_OPC2;
    cyc_d = MMD_CYC_MUL_REG;
    src_ind_d = 1'b0;
    dst_ind_d = 1'b0;
    ill_d = 1'b0;
    swap_d = 1'b0;
    nib_mem = 1'b0;
    case (kind_i)
      MMD_STACK_SLOT_MOVE: begin
        len_d = MMD_LEN_OPC2 + MMD_LEN_ONE + src_ext;
        cyc_d = MMD_CYC_STACK;
        ill_d = !src_if.known || prefix_valid_i;
      end
      MMD_LOAD_EFFECTIVE_ADDRESS_MOVE: begin
        len_d = MMD_LEN_OPC2 + src_ext;
        cyc_d = MMD_CYC_LEA;
        // Register and plain indirect sources carry no displacement
        ill_d = !src_if.known || (src_if.ext == MMD_EXT_NONE) || prefix_valid_i;
        if (dest_sel_i > MMD_LEA_MAX_DEST) begin
          ill_d = 1'b1;
        end
      end
      MMD_NIBBLE_DIRECTION_MOVE: begin
        swap_d = dir_i[1] ^ dir_i[0];
        if (dir_i[3:2] == MMD_NIB_FORM_R0L_SRC) begin
          len_d = MMD_LEN_OPC3 + dst_ext;
          nib_mem = dst_if.is_mem;
          ill_d = !dst_if.known || dst_if.is_addr;
        end else if (dir_i[3:2] == MMD_NIB_FORM_R0L_DST) begin
          len_d = MMD_LEN_OPC3 + src_ext;
          nib_mem = src_if.is_mem;
          ill_d = !src_if.known || src_if.is_addr;
        end else begin
          len_d = MMD_LEN_OPC3;
          ill_d = 1'b1;
        end
        if (prefix_valid_i) begin
          ill_d = 1'b1;
        end
        if (swap_d) begin
          cyc_d = nib_mem ? MMD_CYC_NIB_SWAP_MEM : MMD_CYC_NIB_SWAP_REG;
        end else begin
          cyc_d = nib_mem ? MMD_CYC_NIB_KEEP_MEM : MMD_CYC_NIB_KEEP_REG;
        end
      end
      MMD_SIGN_EXTENDED_IMMEDIATE_MOVE: begin
        len_d = MMD_LEN_OPC3 + dst_ext;
        cyc_d = MMD_CYC_SIGN_EXTENDED_IMMEDIATE_MOVE;
        dst_ind_d = pfx_dst;
        ill_d = !dst_if.known || pfx_src || pfx_both || pfx_bad;
        if ((dst_field_i == MMD_OP_DR2) || (dst_field_i == MMD_OP_DR3)) begin
          ill_d = 1'b1;
        end
      end
      MMD_SIGNED_MULTIPLY_IMM: begin
        len_d = MMD_LEN_OPC3 + dst_ext;
        if (size_i) begin
          len_d = MMD_LEN_OPC3 + MMD_LEN_ONE + dst_ext;
        end
        cyc_d = dst_if.is_mem ? MMD_CYC_MUL_ONE_MEM : MMD_CYC_MUL_REG;
        dst_ind_d = pfx_dst;
        ill_d = !dst_if.known || pfx_src || pfx_both || pfx_bad;
        if (size_i && dst_if.is_mem) begin
          ill_d = 1'b1;
        end
      end
      MMD_SIGNED_MULTIPLY_SRC_DST: begin
        len_d = MMD_LEN_OPC2 + src_ext + dst_ext;
        if (src_if.is_mem && dst_if.is_mem) begin
          cyc_d = MMD_CYC_MUL_TWO_MEM;
        end else if (src_if.is_mem || dst_if.is_mem) begin
          cyc_d = MMD_CYC_MUL_ONE_MEM;
        end else begin
          cyc_d = MMD_CYC_MUL_REG;
        end
        src_ind_d = pfx_src || pfx_both;
        dst_ind_d = pfx_dst || pfx_both;
        ill_d = !src_if.known || !dst_if.known || pfx_bad;
        if (size_i && dst_if.is_mem) begin
          ill_d = 1'b1;
        end
      end
      MMD_SIGNED_MULTIPLY_LONG: begin
        len_d = MMD_LEN_OPC3 + src_ext;
        cyc_d = src_if.is_mem ? MMD_CYC_MULL_MEM : MMD_CYC_MULL_REG;
        ill_d = !src_if.known || prefix_valid_i;
        if ((src_field_i == MMD_OP_DR2) || (src_field_i == MMD_OP_DR3)) begin
          ill_d = 1'b1;
        end
      end
      MMD_EXTENDED_MULTIPLY: begin
        len_d = MMD_LEN_OPC2 + src_ext;
        cyc_d = src_if.is_mem ? MMD_CYC_EXTENDED_MULTIPLY_MEM : MMD_CYC_EXTENDED_MULTIPLY_REG;
        src_ind_d = pfx_dst;
        ill_d = !src_if.known || pfx_src || pfx_both || pfx_bad;
        if (src_if.is_data && (src_field_i != MMD_OP_DR3)) begin
          ill_d = 1'b1;
        end
      end
      default: begin
        len_d = MMD_LEN_ONE;
        ill_d = 1'b1;
      end
    endcase
    one_ind = src_ind_d ^ dst_ind_d;
    both_ind = src_ind_d && dst_ind_d;
    if (one_ind || both_ind) begin
      len_d = len_d + MMD_LEN_ONE;
    end
    if (both_ind) begin
      cyc_d = cyc_d + MMD_CYC_IND_TWO;
    end else if (one_ind) begin
      cyc_d = cyc_d + MMD_CYC_IND_ONE;
    end
  end

  // ---------------------------------------------------------------
  // Result registers
  // ---------------------------------------------------------------
  logic done_q, done_n;
  logic [3:0] len_q, len_n;
  logic [4:0] cyc_q, cyc_n;
  logic src_ind_q, src_ind_n;
  logic dst_ind_q, dst_ind_n;
  logic word_q, word_n;
  logic swap_q, swap_n;
  logic ill_q, ill_n;

  always_comb begin
    done_n = done_q;
    len_n = len_q;
    cyc_n = cyc_q;
    src_ind_n = src_ind_q;
    dst_ind_n = dst_ind_q;
    word_n = word_q;
    swap_n = swap_q;
    ill_n = ill_q;
    if (ce_i) begin
      done_n = dec_valid_i;
      if (dec_valid_i) begin
        len_n = len_d;
        cyc_n = cyc_d;
        src_ind_n = src_ind_d;
        dst_ind_n = dst_ind_d;
        word_n = size_i;
        swap_n = swap_d;
        ill_n = ill_d;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      done_q <= 1'b0;
      len_q <= 4'h0;
      cyc_q <= 5'h00;
      src_ind_q <= 1'b0;
      dst_ind_q <= 1'b0;
      word_q <= 1'b0;
      swap_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      done_q <= done_n;
      len_q <= len_n;
      cyc_q <= cyc_n;
      src_ind_q <= src_ind_n;
      dst_ind_q <= dst_ind_n;
      word_q <= word_n;
      swap_q <= swap_n;
      ill_q <= ill_n;
    end
  end

  assign done_o = done_q;
  assign length_o = len_q;
  assign cycles_o = cyc_q;
  assign src_ind_o = src_ind_q;
  assign dst_ind_o = dst_ind_q;
  assign size_word_o = word_q;
  assign nibble_swap_o = swap_q;
  assign illegal_o = ill_q;

endmodule

// ==== tb/mmd_fetch_model.sv ====
module mmd_fetch_model (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic done_i,
  output logic [7:0] n_ret_o
);
  // ---------------------------------------------------------------
  // Retired instruction count
  // ---------------------------------------------------------------
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] n_ret_q;
  logic [7:0] n_ret_d;
  always_comb begin
    n_ret_d = n_ret_q + {7'h00, done_i};
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      n_ret_q <= 8'h00;
    end else begin
      n_ret_q <= n_ret_d;
    end
  end
  assign n_ret_o = n_ret_q;
endmodule

// ==== tb/mmd_decoder_checker.sv ====
module mmd_decoder_checker (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic dec_valid_i,
  input wire mmd_pkg::mmd_kind_e kind_i,
  input wire logic size_i,
  input wire logic prefix_valid_i,
  input wire logic [7:0] prefix_i,
  input wire logic [4:0] src_field_i,
  input wire logic [4:0] dst_field_i,
  input wire logic [3:0] dir_i,
  input wire logic [2:0] dest_sel_i,
  input wire logic done_o,
  input wire logic [3:0] length_o,
  input wire logic [4:0] cycles_o,
  input wire logic src_ind_o,
  input wire logic dst_ind_o,
  input wire logic size_word_o,
  input wire logic nibble_swap_o,
  input wire logic illegal_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import mmd_pkg::*;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic req;
  logic swp;
  assign req = dec_valid_i && ce_i;
  assign swp = dir_i[1] ^ dir_i[0];
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  AST_DONE_NEXT: assert property (req |-> ##1 done_o) else $error("done missing");
  AST_DONE_PULSE: assert property (ce_i && !req |=> !done_o) else $error("done without request");
  AST_HOLD: assert property (!req |=> $stable(length_o) && $stable(cycles_o) && $stable(illegal_o))
    else $error("result changed without request");
  AST_SIZE: assert property (req |=> size_word_o == $past(size_i)) else $error("size bit wrong");
  AST_SIGN_EXTENDED_IMMEDIATE_MOVE_IND: assert property (req && kind_i == MMD_SIGN_EXTENDED_IMMEDIATE_MOVE && prefix_valid_i &&
    prefix_i == MMD_PFX_DST_IND |=> dst_ind_o && !src_ind_o && cycles_o == 5'h05) else $error("dest prefix");
  AST_MUL_BOTH: assert property (req && kind_i == MMD_SIGNED_MULTIPLY_SRC_DST && prefix_valid_i &&
    prefix_i == MMD_PFX_BOTH_IND && src_field_i[4:2] == 3'h4 && dst_field_i[4:2] == 3'h4
    |=> src_ind_o && dst_ind_o && cycles_o == 5'h09) else $error("both prefix");
  AST_LONG_PFX: assert property (req && kind_i == MMD_SIGNED_MULTIPLY_LONG && prefix_valid_i |=> illegal_o)
    else $error("long multiply prefix accepted");
  AST_STACK_CYC: assert property (req && kind_i == MMD_STACK_SLOT_MOVE |=> illegal_o || cycles_o == 5'h03)
    else $error("stack move cycles");
  AST_LEA_CYC: assert property (req && kind_i == MMD_LOAD_EFFECTIVE_ADDRESS_MOVE |=> illegal_o ||
    cycles_o == 5'h02) else $error("address load cycles");
  AST_NIB_AN: assert property (req && kind_i == MMD_NIBBLE_DIRECTION_MOVE && dir_i[3:2] == 2'h1 &&
    dst_field_i[4:1] == 4'h1 |=> illegal_o) else $error("address register nibble operand");
  AST_NIB_SWAP: assert property (req && kind_i == MMD_NIBBLE_DIRECTION_MOVE |=> nibble_swap_o == $past(swp))
    else $error("nibble swap flag");
  AST_EXTENDED_MULTIPLY_DR: assert property (req && kind_i == MMD_EXTENDED_MULTIPLY && src_field_i[4:2] == 3'h4 &&
    src_field_i[1:0] != 2'h1 |=> illegal_o) else $error("extended multiply source");
endmodule

bind mmd_decoder mmd_decoder_checker mmd_decoder_checker_inst (.sys_clk_i, .rst_b_i, .ce_i, .dec_valid_i, .kind_i,
  .size_i, .prefix_valid_i, .prefix_i, .src_field_i, .dst_field_i, .dir_i, .dest_sel_i, .done_o, .length_o,
  .cycles_o, .src_ind_o, .dst_ind_o, .size_word_o, .nibble_swap_o, .illegal_o);

// ==== tb/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mmd_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus and result signals
  // ---------------------------------------------------------------
  localparam mmd_kind_e KSM = MMD_STACK_SLOT_MOVE;
  localparam mmd_kind_e KLA = MMD_LOAD_EFFECTIVE_ADDRESS_MOVE;
  localparam mmd_kind_e KNB = MMD_NIBBLE_DIRECTION_MOVE;
  localparam mmd_kind_e KSX = MMD_SIGN_EXTENDED_IMMEDIATE_MOVE;
  localparam mmd_kind_e KMI = MMD_SIGNED_MULTIPLY_IMM;
  localparam mmd_kind_e KM2 = MMD_SIGNED_MULTIPLY_SRC_DST;
  localparam mmd_kind_e KML = MMD_SIGNED_MULTIPLY_LONG;
  localparam mmd_kind_e KEX = MMD_EXTENDED_MULTIPLY;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic dec_valid_i = 1'b0;
  mmd_kind_e kind_i = MMD_OTHER;
  logic size_i = 1'b0;
  logic prefix_valid_i = 1'b0;
  logic [7:0] prefix_i = 8'h00;
  logic [4:0] src_field_i = 5'h00;
  logic [4:0] dst_field_i = 5'h00;
  logic [3:0] dir_i = 4'h0;
  logic [2:0] dest_sel_i = 3'h0;
  logic done_o, src_ind_o, dst_ind_o, size_word_o, nibble_swap_o, illegal_o;
  logic [3:0] length_o;
  logic [4:0] cycles_o;
  logic [7:0] n_ret;
  logic [15:0] e;
  logic [15:0] exp_q[$];
  int n_errors = 0;
  int checks = 0;
  int seed = 79;
  int cyc = 0;
  int n_req = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  mmd_decoder mmd_decoder_inst (.sys_clk_i, .rst_b_i, .ce_i, .dec_valid_i, .kind_i, .size_i, .prefix_valid_i,
    .prefix_i, .src_field_i, .dst_field_i, .dir_i, .dest_sel_i, .done_o, .length_o, .cycles_o, .src_ind_o,
    .dst_ind_o, .size_word_o, .nibble_swap_o, .illegal_o);
  mmd_fetch_model mmd_fetch_model_inst (.sys_clk_i, .rst_b_i, .done_i(done_o), .n_ret_o(n_ret));

  // ---------------------------------------------------------------
  // Compare, verdict and driver
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic t(input mmd_kind_e k, input logic sz, input logic [7:0] pf, input logic [4:0] s,
    input logic [4:0] d, input logic [3:0] ax, input logic [3:0] ln, input logic [4:0] cy, input logic [2:0] fl);
    logic [31:0] r;
    r = $random(seed);
    kind_i <= k;
    size_i <= sz;
    prefix_valid_i <= (pf != 8'h00);
    prefix_i <= pf;
    src_field_i <= s;
    dst_field_i <= d;
    dir_i <= (k == KNB) ? ax : r[3:0];
    dest_sel_i <= (k == KLA) ? ax[2:0] : r[6:4];
    dec_valid_i <= 1'b1;
    n_req++;
    exp_q.push_back({ln != 4'h0, k == KNB, ax[1] ^ ax[0], sz, fl, ln, cy});
    @(posedge sys_clk_i);
    if (r[8]) begin
      dec_valid_i <= 1'b0;
      @(posedge sys_clk_i);
      if (r[9]) begin
        // Request while frozen must be ignored
        ce_i <= 1'b0;
        dec_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        ce_i <= 1'b1;
        dec_valid_i <= 1'b0;
        @(posedge sys_clk_i);
      end
    end
  endtask

  always @(negedge sys_clk_i) begin
    if (done_o === 1'b1) begin
      e = exp_q.pop_front();
      if (e[15]) begin
        chk({4'h0, length_o}, {4'h0, e[8:5]});
        chk({3'h0, cycles_o}, {3'h0, e[4:0]});
      end
      chk({4'h0, illegal_o, src_ind_o, dst_ind_o, size_word_o}, {4'h0, e[11:9], e[12]});
      if (e[14]) begin
        chk({7'h00, nibble_swap_o}, {7'h00, e[13]});
      end
    end
  end

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 400) begin
      n_errors++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    t(KSM, 1'h0, 8'h00, 5'h12, 5'h00, 4'h0, 4'h3, 5'h03, 3'h0);
    t(KSM, 1'h1, 8'h00, 5'h0e, 5'h00, 4'h0, 4'h6, 5'h03, 3'h0);
    t(KSM, 1'h0, 8'h00, 5'h14, 5'h00, 4'h0, 4'h0, 5'h00, 3'h4);
    t(KLA, 1'h0, 8'h00, 5'h04, 5'h00, 4'h0, 4'h3, 5'h02, 3'h0);
    t(KLA, 1'h0, 8'h00, 5'h0e, 5'h00, 4'h3, 4'h5, 5'h02, 3'h0);
    t(KLA, 1'h0, 8'h00, 5'h12, 5'h00, 4'h1, 4'h0, 5'h00, 3'h4);
    t(KLA, 1'h0, 8'h00, 5'h0f, 5'h00, 4'h4, 4'h0, 5'h00, 3'h4);
    t(KNB, 1'h0, 8'h00, 5'h00, 5'h12, 4'h4, 4'h3, 5'h03, 3'h0);
    t(KNB, 1'h0, 8'h00, 5'h00, 5'h0f, 4'h5, 4'h5, 5'h08, 3'h0);
    t(KNB, 1'h0, 8'h00, 5'h00, 5'h00, 4'h6, 4'h3, 5'h08, 3'h0);
    t(KNB, 1'h0, 8'h00, 5'h00, 5'h13, 4'h7, 4'h3, 5'h03, 3'h0);
    t(KNB, 1'h0, 8'h00, 5'h06, 5'h00, 4'h3, 4'h4, 5'h05, 3'h0);
    t(KNB, 1'h0, 8'h00, 5'h10, 5'h00, 4'h1, 4'h3, 5'h06, 3'h0);
    t(KNB, 1'h0, 8'h00, 5'h00, 5'h02, 4'h4, 4'h0, 5'h00, 3'h4);
    t(KSX, 1'h0, 8'h00, 5'h00, 5'h12, 4'h0, 4'h3, 5'h02, 3'h0);
    t(KSX, 1'h0, 8'h00, 5'h00, 5'h0c, 4'h0, 4'h6, 5'h02, 3'h0);
    t(KSX, 1'h0, 8'h09, 5'h00, 5'h04, 4'h0, 4'h5, 5'h05, 3'h1);
    t(KSX, 1'h0, 8'h00, 5'h00, 5'h10, 4'h0, 4'h0, 5'h00, 3'h4);
    t(KMI, 1'h0, 8'h00, 5'h00, 5'h12, 4'h0, 4'h3, 5'h03, 3'h0);
    t(KMI, 1'h1, 8'h00, 5'h00, 5'h13, 4'h0, 4'h4, 5'h03, 3'h0);
    t(KMI, 1'h1, 8'h00, 5'h00, 5'h04, 4'h0, 4'h0, 5'h00, 3'h4);
    t(KMI, 1'h0, 8'h09, 5'h00, 5'h00, 4'h0, 4'h4, 5'h08, 3'h1);
    t(KM2, 1'h0, 8'h00, 5'h12, 5'h13, 4'h0, 4'h2, 5'h03, 3'h0);
    t(KM2, 1'h0, 8'h00, 5'h04, 5'h12, 4'h0, 4'h3, 5'h05, 3'h0);
    t(KM2, 1'h0, 8'h00, 5'h04, 5'h06, 4'h0, 4'h4, 5'h06, 3'h0);
    t(KM2, 1'h0, 8'h49, 5'h04, 5'h12, 4'h0, 4'h4, 5'h0b, 3'h3);
    t(KM2, 1'h0, 8'h49, 5'h12, 5'h13, 4'h0, 4'h3, 5'h09, 3'h3);
    t(KM2, 1'h0, 8'h41, 5'h00, 5'h12, 4'h0, 4'h3, 5'h08, 3'h2);
    t(KM2, 1'h0, 8'h09, 5'h12, 5'h00, 4'h0, 4'h3, 5'h08, 3'h1);
    t(KM2, 1'h1, 8'h00, 5'h12, 5'h06, 4'h0, 4'h0, 5'h00, 3'h4);
    t(KML, 1'h0, 8'h00, 5'h12, 5'h00, 4'h0, 4'h3, 5'h08, 3'h0);
    t(KML, 1'h0, 8'h00, 5'h04, 5'h00, 4'h0, 4'h4, 5'h09, 3'h0);
    t(KML, 1'h0, 8'h09, 5'h12, 5'h00, 4'h0, 4'h0, 5'h00, 3'h4);
    t(KEX, 1'h0, 8'h00, 5'h11, 5'h00, 4'h0, 4'h2, 5'h08, 3'h0);
    t(KEX, 1'h0, 8'h00, 5'h00, 5'h00, 4'h0, 4'h2, 5'h0a, 3'h0);
    t(KEX, 1'h0, 8'h00, 5'h12, 5'h00, 4'h0, 4'h0, 5'h00, 3'h4);
    t(KEX, 1'h0, 8'h09, 5'h04, 5'h00, 4'h0, 4'h4, 5'h0d, 3'h2);
    t(MMD_OTHER, 1'h0, 8'h00, 5'h00, 5'h00, 4'h0, 4'h0, 5'h00, 3'h4);
    dec_valid_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    chk(n_ret, n_req[7:0]);
    give_verdict();
  end
endmodule
